// ===== prover_pkg.sv
// Functional notes
// RL1 - detector triggers come from hardware detector pins or a software trigger command
// RL2 - any level change on a detector pin counts as a trigger
// RL3 - whole pulse counting starts at first trigger after arming, stops at second
// RL4 - after an accepted transition further transitions are ignored for the filter interval
// RL5 - proving counts one selected pulse input only, chosen by a selector
// RL6 - host resets before each prove; reset clears totals and arms the block
// RL7 - communication loss during a prove flags the counts invalid
// RL8 - interpolation timestamps are always produced alongside the whole count
// RL9 - falling detector edge raises an event carrying a timebase timestamp
// RL10 - two indicator outputs show firmware, programming, erasing and detector activity
// RL11 - master meter input selection only applies when software trigger is enabled
// RL12 - two detector inputs together gate accumulation
// RL13 - present contact level of each detector is reported open or closed
// RL14 - after reset command the state reads armed
// RL15 - after first transition the state reads counting while accumulating
// RL16 - after second transition state reads complete, counts held until next reset
// RL17 - power-up or comm loss during prove zeroes counts, state invalid
// RL18 - filter interval is set in milliseconds, measured from the accepted trigger
// RL19 - an accepted software trigger returns its control to idle by itself
// RL20 - reset command clears whole counts, interpolation data and pending alarms
// RL21 - filter is a cycle down-counter loaded on acceptance, masking while non-zero
package prover_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned CYC_PER_MS_DFLT = CLK_HZ / MS_PER_S;
    localparam int unsigned BLINK_MS = 250;
    localparam int unsigned BLINK_CYC_DFLT = BLINK_MS * CYC_PER_MS_DFLT;
    localparam int unsigned N_DET = 2;
    localparam int unsigned N_PULSE = 4;
    localparam int unsigned TS_W = 32;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned FMS_W = 8;
    localparam int unsigned DEB_W = 32;
    localparam logic DET_RST_LVL = 1'h1;

    typedef enum logic [1:0] {
        ST_INVALID = 2'h0,
        ST_ARMED = 2'h1,
        ST_COUNTING = 2'h2,
        ST_COMPLETE = 2'h3
    } prove_state_t;

    typedef enum logic [1:0] {
        FW_RUN = 2'h0,
        FW_NONE = 2'h1,
        FW_PROG = 2'h2,
        FW_ERASE = 2'h3
    } fw_mode_t;
endpackage : prover_pkg

// ===== detector_filter.sv
`timescale 1ns/100ps
`default_nettype none
module detector_filter #(
    parameter int unsigned CYC_PER_MS = prover_pkg::CYC_PER_MS_DFLT,
    parameter int unsigned FMS_W = prover_pkg::FMS_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic det_pin,
    input wire logic [FMS_W-1:0] filter_ms,
    output logic level,
    output logic trig,
    output logic fall
);
    localparam int DW = prover_pkg::DEB_W;
    logic s1_r, s2_r, acc_r, trig_r, fall_r;
    logic [DW-1:0] cnt_r, cnt_nxt, load_w;
    logic take_w;

    // pin synchroniser; only s2_r is looked at
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= prover_pkg::DET_RST_LVL;
            s2_r <= prover_pkg::DET_RST_LVL;
        end else begin
            s1_r <= det_pin;
            s2_r <= s1_r;
        end
    end

    // either direction of change is a trigger, but only once the mask has run out
    assign take_w = (s2_r != acc_r) && (cnt_r == '0); // RL2 RL4
    // filter time in ms turned into module clock cycles
    assign load_w = DW'(filter_ms) * DW'(CYC_PER_MS); // RL18
    assign cnt_nxt = take_w ? load_w : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r); // RL21

    // a change that ends during the mask is still seen afterwards if the level stayed
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_r <= prover_pkg::DET_RST_LVL;
            cnt_r <= '0;
            trig_r <= 1'h0;
            fall_r <= 1'h0;
        end else begin
            acc_r <= take_w ? s2_r : acc_r;
            cnt_r <= cnt_nxt;
            trig_r <= take_w;
            fall_r <= take_w & ~s2_r;
        end
    end

    assign level = s2_r;
    assign trig = trig_r;
    assign fall = fall_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    mask_hold_a: assert property (take_w && load_w != '0 |=> !take_w) // RL4
        else $error("transition accepted inside filter interval");
    any_change_a: assert property (take_w |=> trig && acc_r != $past(acc_r)) // RL2
        else $error("accepted change did not raise a trigger");
    filter_load_a: assert property (take_w |=> cnt_r == $past(load_w)) // RL21
        else $error("filter counter not loaded from ms setting");
    filter_count_a: assert property (cnt_r != '0 |=> cnt_r == $past(cnt_r) - 1'b1) // RL18
        else $error("filter counter did not count down");
endmodule : detector_filter
`default_nettype wire

// ===== pulse_module_prover.sv
`timescale 1ns/100ps
`default_nettype none
module pulse_module_prover #(
    parameter int unsigned N_PULSE = prover_pkg::N_PULSE,
    parameter int unsigned SEL_W = $clog2(N_PULSE),
    parameter int unsigned FMS_W = prover_pkg::FMS_W,
    parameter int unsigned CYC_PER_MS = prover_pkg::CYC_PER_MS_DFLT,
    parameter int unsigned BLINK_CYC = prover_pkg::BLINK_CYC_DFLT
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [prover_pkg::N_DET-1:0] det_pin,
    input wire logic [N_PULSE-1:0] pulse_pin,
    input wire logic [SEL_W-1:0] meter_sel,
    input wire logic [SEL_W-1:0] master_sel,
    input wire logic master_mode,
    input wire logic sw_trig_en,
    input wire logic sw_trig,
    input wire logic reset_cmd,
    input wire logic comm_lost,
    input wire logic [FMS_W-1:0] filter_ms,
    input wire logic [1:0] fw_mode,
    output logic [1:0] prove_state,
    output logic [prover_pkg::CNT_W-1:0] whole_count,
    output logic count_alarm,
    output logic [prover_pkg::TS_W-1:0] start_ts,
    output logic [prover_pkg::TS_W-1:0] stop_ts,
    output logic [prover_pkg::TS_W-1:0] pre_pulse_ts,
    output logic [prover_pkg::TS_W-1:0] last_pulse_ts,
    output logic [prover_pkg::TS_W-1:0] post_pulse_ts,
    output logic fall_evt,
    output logic fall_det,
    output logic [prover_pkg::TS_W-1:0] fall_ts,
    output logic [prover_pkg::N_DET-1:0] contact_closed,
    output logic sw_trig_pend,
    output logic det_led,
    output logic switch_indicator_led
);
    localparam int TW = prover_pkg::TS_W;
    localparam int CW = prover_pkg::CNT_W;
    localparam int ND = prover_pkg::N_DET;
    localparam int BW = $clog2(BLINK_CYC + 1);
    localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_CYC - 1);

    prover_pkg::prove_state_t state_r, state_nxt;
    logic [ND-1:0] det_trig_w, det_fall_w;
    logic [N_PULSE-1:0] pls_s1_r, pls_s2_r, pls_s3_r;
    logic [SEL_W-1:0] sel_w;
    logic rise_w, run_w, lost_w, clr_w, sw_acc_w, trig_w, start_w, stop_w;
    logic cnt_en_w, cnt_max_w, post_seen_r;
    logic [TW-1:0] tb_r;
    logic [CW-1:0] whole_r;
    logic alarm_r, sw_pend_r, fall_evt_r, fall_det_r;
    logic [TW-1:0] start_ts_r, stop_ts_r, pre_ts_r, last_ts_r, post_ts_r, fall_ts_r;
    logic [BW-1:0] blink_r;
    logic phase_r, tick_w, det_led_r, sw_led_r, det_led_nxt, sw_led_nxt;
    logic [ND-1:0] act_r;
    prover_pkg::fw_mode_t fw_w;

    // one filter per detector contact
    for (genvar i = 0; i < ND; i++) begin : g_det // RL12
        detector_filter #(
            .CYC_PER_MS(CYC_PER_MS),
            .FMS_W(FMS_W)
        ) u_filt (
            .clk(clk),
            .arst_n(arst_n),
            .det_pin(det_pin[i]),
            .filter_ms(filter_ms),
            .level(contact_closed[i]), // RL13
            .trig(det_trig_w[i]),
            .fall(det_fall_w[i])
        );
    end

    // pulse pins pass two flops; the third stage only feeds edge detection
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pls_s1_r <= '0;
            pls_s2_r <= '0;
            pls_s3_r <= '0;
        end else begin
            pls_s1_r <= pulse_pin;
            pls_s2_r <= pls_s1_r;
            pls_s3_r <= pls_s2_r;
        end
    end

    // master meter input only counts when software triggering is enabled
    assign sel_w = (master_mode && sw_trig_en) ? master_sel : meter_sel; // RL11
    assign rise_w = pls_s2_r[sel_w] & ~pls_s3_r[sel_w]; // RL5

    // trigger source: software command or hardware contacts, never both
    assign run_w = (state_r == prover_pkg::ST_ARMED) || (state_r == prover_pkg::ST_COUNTING);
    assign sw_acc_w = sw_trig_en && sw_pend_r && run_w; // RL1
    assign trig_w = sw_trig_en ? sw_acc_w : (|det_trig_w); // RL1 RL12
    assign lost_w = comm_lost && run_w; // RL7
    assign clr_w = reset_cmd || lost_w; // RL6 RL17
    assign start_w = !clr_w && trig_w && (state_r == prover_pkg::ST_ARMED);
    assign stop_w = !clr_w && trig_w && (state_r == prover_pkg::ST_COUNTING);
    // a pulse edge in the stop cycle is left out of the run
    assign cnt_en_w = !clr_w && !stop_w && rise_w && (state_r == prover_pkg::ST_COUNTING);
    assign cnt_max_w = &whole_r;

    // prove sequencer; reset command beats a communication loss
    always_comb begin
        state_nxt = state_r;
        if (reset_cmd) begin
            state_nxt = prover_pkg::ST_ARMED; // RL6 RL14
        end else if (lost_w) begin
            state_nxt = prover_pkg::ST_INVALID; // RL7 RL17
        end else begin
            unique case (state_r)
                prover_pkg::ST_INVALID: state_nxt = prover_pkg::ST_INVALID;
                prover_pkg::ST_ARMED: begin
                    if (trig_w) state_nxt = prover_pkg::ST_COUNTING; // RL3 RL15
                end
                prover_pkg::ST_COUNTING: begin
                    if (trig_w) state_nxt = prover_pkg::ST_COMPLETE; // RL3 RL16
                end
                prover_pkg::ST_COMPLETE: state_nxt = prover_pkg::ST_COMPLETE; // RL16
            endcase
        end
    end

    // power-up shows invalid data until the first reset command
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) state_r <= prover_pkg::ST_INVALID; // RL17
        else state_r <= state_nxt;
    end

    // free-running timebase at the module clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) tb_r <= '0;
        else tb_r <= tb_r + 1'b1;
    end

    // whole pulse accumulator and its overflow alarm; counter saturates
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            whole_r <= '0;
            alarm_r <= 1'h0;
        end else if (clr_w) begin
            whole_r <= '0; // RL17 RL20
            alarm_r <= 1'h0; // RL20
        end else if (cnt_en_w) begin
            whole_r <= cnt_max_w ? whole_r : whole_r + 1'b1; // RL3
            alarm_r <= alarm_r | cnt_max_w;
        end
    end

    // pulse and detector timestamps for interpolation around each detector
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            start_ts_r <= '0;
            stop_ts_r <= '0;
            pre_ts_r <= '0;
            last_ts_r <= '0;
            post_ts_r <= '0;
            post_seen_r <= 1'h0;
        end else if (clr_w) begin
            start_ts_r <= '0; // RL20
            stop_ts_r <= '0;
            pre_ts_r <= '0;
            last_ts_r <= '0;
            post_ts_r <= '0;
            post_seen_r <= 1'h0;
        end else begin
            if (start_w) start_ts_r <= tb_r; // RL8
            if (stop_w) stop_ts_r <= tb_r; // RL8
            if (rise_w && state_r == prover_pkg::ST_ARMED) pre_ts_r <= tb_r;
            if (cnt_en_w) last_ts_r <= tb_r;
            if (rise_w && state_r == prover_pkg::ST_COMPLETE && !post_seen_r) begin
                post_ts_r <= tb_r; // RL8
                post_seen_r <= 1'h1;
            end
        end
    end

    // software trigger stays pending until taken or until sw_trig_en drops; a new command wins over the clear on taking, not over sw_trig_en low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) sw_pend_r <= 1'h0;
        else if (!sw_trig_en) sw_pend_r <= 1'h0;
        else if (sw_trig) sw_pend_r <= 1'h1;
        else if (sw_acc_w) sw_pend_r <= 1'h0; // RL19
    end

    // falling detector edge event, stamped with the timebase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fall_evt_r <= 1'h0;
            fall_det_r <= 1'h0;
            fall_ts_r <= '0;
        end else begin
            fall_evt_r <= |det_fall_w; // RL9
            if (|det_fall_w) begin
                fall_ts_r <= tb_r; // RL9
                fall_det_r <= ~det_fall_w[0]; // detector 0 wins a tie
            end
        end
    end

    // blink timebase for the indicators
    assign tick_w = (blink_r == '0);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            blink_r <= BLINK_LAST;
            phase_r <= 1'h0;
        end else begin
            blink_r <= tick_w ? BLINK_LAST : blink_r - 1'b1;
            phase_r <= tick_w ? ~phase_r : phase_r;
        end
    end

    // indicator patterns; in normal running each lamp blinks on its own activity
    assign fw_w = prover_pkg::fw_mode_t'(fw_mode);
    assign det_led_nxt = (fw_w == prover_pkg::FW_ERASE) ? 1'h1 :
                         (fw_w != prover_pkg::FW_RUN) ? phase_r :
                         (act_r[0] ? (det_led_r ^ tick_w) : 1'h0); // RL10
    assign sw_led_nxt = (fw_w == prover_pkg::FW_ERASE) ? 1'h1 :
                        (fw_w == prover_pkg::FW_NONE) ? phase_r :
                        (fw_w == prover_pkg::FW_PROG) ? ~phase_r :
                        (act_r[1] ? (sw_led_r ^ tick_w) : 1'h0); // RL10

    // activity latches hold until the next blink tick; a new trigger wins over the clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            act_r <= '0;
            det_led_r <= 1'h0;
            sw_led_r <= 1'h0;
        end else begin
            act_r[0] <= det_trig_w[0] | (act_r[0] & ~tick_w);
            act_r[1] <= det_trig_w[1] | sw_acc_w | (act_r[1] & ~tick_w);
            det_led_r <= det_led_nxt;
            sw_led_r <= sw_led_nxt;
        end
    end

    assign prove_state = state_r;
    assign whole_count = whole_r;
    assign count_alarm = alarm_r;
    assign start_ts = start_ts_r;
    assign stop_ts = stop_ts_r;
    assign pre_pulse_ts = pre_ts_r;
    assign last_pulse_ts = last_ts_r;
    assign post_pulse_ts = post_ts_r;
    assign fall_evt = fall_evt_r;
    assign fall_det = fall_det_r;
    assign fall_ts = fall_ts_r;
    assign sw_trig_pend = sw_pend_r;
    assign det_led = det_led_r;
    assign switch_indicator_led = sw_led_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    reset_arms_a: assert property (reset_cmd |=> state_r == prover_pkg::ST_ARMED // RL6
        && whole_r == '0 && !alarm_r && start_ts_r == '0) // RL14 RL20
        else $error("reset command did not clear and arm");
    first_trig_a: assert property (state_r == prover_pkg::ST_ARMED && trig_w && !clr_w // RL3
        |=> state_r == prover_pkg::ST_COUNTING && start_ts_r == $past(tb_r)) // RL15 RL8
        else $error("first trigger did not start counting");
    second_trig_a: assert property (stop_w // RL3
        |=> state_r == prover_pkg::ST_COMPLETE && stop_ts_r == $past(tb_r)) // RL16
        else $error("second trigger did not complete the prove");
    complete_hold_a: assert property (state_r == prover_pkg::ST_COMPLETE && !reset_cmd // RL16
        |=> state_r == prover_pkg::ST_COMPLETE && $stable(whole_r) && $stable(stop_ts_r))
        else $error("completed counts changed before reset");
    comm_lost_a: assert property (state_r == prover_pkg::ST_COUNTING && comm_lost // RL7
        && !reset_cmd |=> state_r == prover_pkg::ST_INVALID && whole_r == '0) // RL17
        else $error("comm loss did not invalidate counts");
    pulse_count_a: assert property (cnt_en_w && !cnt_max_w // RL5
        |=> whole_r == $past(whole_r) + 1'b1)
        else $error("selected pulse edge not counted");
    idle_count_a: assert property (state_r != prover_pkg::ST_COUNTING && !reset_cmd // RL3
        |=> $stable(whole_r) || whole_r == '0)
        else $error("pulses counted outside a run");
    master_sel_a: assert property (!sw_trig_en && $stable(meter_sel) // RL11
        ##1 !sw_trig_en |-> sel_w == meter_sel)
        else $error("master input used without software trigger");
    sw_idle_a: assert property (sw_acc_w && !sw_trig |=> !sw_pend_r) // RL19
        else $error("software trigger did not return to idle");
    fall_stamp_a: assert property (|det_fall_w // RL9
        |=> fall_evt_r && fall_ts_r == $past(tb_r))
        else $error("falling edge event missing or stamp wrong");
    erase_leds_a: assert property (fw_mode == prover_pkg::FW_ERASE // RL10
        |=> det_led_r && sw_led_r)
        else $error("indicators not steady while erasing");

    run_done_c: cover property (state_r == prover_pkg::ST_COUNTING ##[1:1000]
        state_r == prover_pkg::ST_COMPLETE);
    lost_c: cover property (state_r == prover_pkg::ST_COUNTING ##1
        state_r == prover_pkg::ST_INVALID);
    sw_trig_c: cover property (sw_acc_w);
    fall_c: cover property (fall_evt_r && fall_det_r);
endmodule : pulse_module_prover
`default_nettype wire

// ===== prover_far_side.sv
`timescale 1ns/100ps
`default_nettype none
// far side: prover detector contacts and meter pulse heads, driven on falling edges
module prover_far_side (
    input wire logic clk,
    output logic [1:0] det_pin,
    output logic [3:0] pulse_pin
);
    // normally closed contacts rest closed, heads rest low
    initial begin
        det_pin = 2'h3;
        pulse_pin = 4'h0;
    end

    // a trip flips a contact; either direction is a legal trip
    task automatic flip(input int i);
        @(negedge clk);
        det_pin[i] = ~det_pin[i];
    endtask : flip

    // contact chatter: two short flips that end at the level it started from
    task automatic bounce(input int i);
        repeat (2) begin
            @(negedge clk);
            det_pin[i] = ~det_pin[i];
            @(negedge clk);
        end
    endtask : bounce

    // pulses held three cycles so the two-flop sync always sees them
    task automatic pulses(input logic [3:0] mask, input int n);
        repeat (n) begin
            @(negedge clk);
            pulse_pin = mask;
            repeat (3) @(negedge clk);
            pulse_pin = 4'h0;
            repeat (2) @(negedge clk);
        end
    endtask : pulses
endmodule : prover_far_side
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, exp, got) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module testbench;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic [1:0] det_pin;
    logic [3:0] pulse_pin;
    logic [1:0] meter_sel = 2'h2;
    logic [1:0] master_sel = 2'h3;
    logic master_mode = 1'h0;
    logic sw_trig_en = 1'h0;
    logic sw_trig = 1'h0;
    logic reset_cmd = 1'h0;
    logic comm_lost = 1'h0;
    logic [7:0] filter_ms = 8'h02;
    logic [1:0] fw_mode = 2'h0;
    logic [1:0] prove_state;
    logic [31:0] whole_count;
    logic [31:0] start_ts;
    logic [31:0] stop_ts;
    logic [31:0] fall_ts;
    logic count_alarm;
    logic [31:0] pre_pulse_ts;
    logic [31:0] last_pulse_ts;
    logic [31:0] post_pulse_ts;
    logic fall_evt;
    logic fall_det;
    logic [1:0] contact_closed;
    logic sw_trig_pend;
    logic det_led;
    logic switch_indicator_led;
    int n_errors = 0;
    int total_checks = 0;
    int n_fall = 0;
    logic [31:0] cyc = 32'h0;
    logic [31:0] t_a;
    logic [1:0] lamps_exp;
    logic [1:0] lamps_first;
    logic toggled;

    // 100 MHz clock and a free cycle count for timestamp deltas
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 32'h1;

    // one-cycle fall events counted at the falling edge, where they stand settled
    always @(negedge clk) begin
        if (fall_evt === 1'h1) n_fall++;
    end

    prover_far_side far_u (.clk(clk), .det_pin(det_pin), .pulse_pin(pulse_pin));

    // short millisecond and blink counts keep the run small
    pulse_module_prover #(.CYC_PER_MS(10), .BLINK_CYC(8)) dut_u (
        .clk(clk), .arst_n(arst_n), .det_pin(det_pin), .pulse_pin(pulse_pin),
        .meter_sel(meter_sel), .master_sel(master_sel), .master_mode(master_mode),
        .sw_trig_en(sw_trig_en), .sw_trig(sw_trig), .reset_cmd(reset_cmd),
        .comm_lost(comm_lost), .filter_ms(filter_ms), .fw_mode(fw_mode),
        .prove_state(prove_state), .whole_count(whole_count), .count_alarm(count_alarm),
        .start_ts(start_ts), .stop_ts(stop_ts), .pre_pulse_ts(pre_pulse_ts),
        .last_pulse_ts(last_pulse_ts), .post_pulse_ts(post_pulse_ts), .fall_evt(fall_evt),
        .fall_det(fall_det), .fall_ts(fall_ts),
        .contact_closed(contact_closed), .sw_trig_pend(sw_trig_pend), .det_led(det_led),
        .switch_indicator_led(switch_indicator_led)
    );

    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    // one-cycle host command: 0 reset command, 1 software trigger
    task automatic cmd(input int k);
        @(negedge clk);
        if (k == 0) reset_cmd = 1'h1;
        else sw_trig = 1'h1;
        @(negedge clk);
        reset_cmd = 1'h0;
        sw_trig = 1'h0;
    endtask : cmd

    // bounded wait: a pending filter mask may delay a trigger by up to 20 cycles
    task automatic wait_state(input logic [1:0] s);
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            if (prove_state === s) break;
        end
        `CHECK("prove_state", s, prove_state)
    endtask : wait_state

    initial begin
        #100000;
        n_errors++;
        conclude();
    end

    initial begin
        repeat (20) @(negedge clk);
        arst_n = 1'h1;
        repeat (3) @(negedge clk);
        `CHECK("power-up state", 2'h0, prove_state)
        `CHECK("power-up count", 32'h0, whole_count)
        `CHECK("contacts closed", 2'h3, contact_closed)
        // hardware prove on meter input 2 with chatter after the start trip
        cmd(0);
        wait_state(2'h1);
        far_u.flip(0);
        t_a = cyc;
        wait_state(2'h2);
        `CHECK("start detector", 1'h0, fall_det)
        `CHECK("start stamp", fall_ts, start_ts)
        far_u.bounce(0);
        far_u.pulses(4'h4, 5);
        far_u.pulses(4'h2, 3);
        `CHECK("chatter masked", 2'h2, prove_state)
        far_u.flip(1);
        t_a = cyc - t_a;
        wait_state(2'h3);
        `CHECK("whole count", 32'h5, whole_count)
        `CHECK("stamp span", t_a, stop_ts - start_ts)
        `CHECK("stop detector", 1'h1, fall_det)
        `CHECK("contacts open", 2'h0, contact_closed)
        far_u.pulses(4'h4, 2);
        `CHECK("held state", 2'h3, prove_state)
        `CHECK("held count", 32'h5, whole_count)
        `CHECK("no alarm", 1'h0, count_alarm)
        // start and stop falls only: the chatter was masked
        `CHECK("fall events", 32'h2, n_fall)
        // last pin 2 pulse set 24 cycles before the stop trip, one stage shorter path
        `CHECK("last pulse stamp", 32'h19, stop_ts - last_pulse_ts)
        `CHECK("post pulse stamp", 32'h4, post_pulse_ts - stop_ts)
        // comm loss mid-prove; rising contact change starts this one
        // master select is ignored while software triggering is off
        repeat (30) @(negedge clk);
        master_mode = 1'h1;
        cmd(0);
        wait_state(2'h1);
        `CHECK("count cleared", 32'h0, whole_count)
        far_u.pulses(4'h4, 1);
        `CHECK("armed count", 32'h0, whole_count)
        far_u.flip(0);
        wait_state(2'h2);
        `CHECK("pre pulse stamp", 32'h7, start_ts - pre_pulse_ts)
        far_u.pulses(4'h4, 2);
        `CHECK("meter count", 32'h2, whole_count)
        comm_lost = 1'h1;
        wait_state(2'h0);
        comm_lost = 1'h0;
        `CHECK("lost count", 32'h0, whole_count)
        // master meter prove on input 3, contacts do not gate it
        sw_trig_en = 1'h1;
        master_mode = 1'h1;
        cmd(0);
        wait_state(2'h1);
        cmd(1);
        wait_state(2'h2);
        `CHECK("trigger idle", 1'h0, sw_trig_pend)
        far_u.flip(1);
        repeat (10) @(negedge clk);
        `CHECK("contacts ignored", 2'h2, prove_state)
        far_u.pulses(4'h8, 4);
        far_u.pulses(4'h4, 2);
        cmd(1);
        wait_state(2'h3);
        `CHECK("master count", 32'h4, whole_count)
        sw_trig_en = 1'h0;
        master_mode = 1'h0;
        // lamp patterns: together, alternating, steady on
        for (int m = 1; m < 4; m++) begin
            fw_mode = m[1:0];
            repeat (4) @(negedge clk);
            lamps_first = {det_led, switch_indicator_led};
            toggled = 1'h0;
            for (int c = 0; c < 24; c++) begin
                @(negedge clk);
                if ({det_led, switch_indicator_led} !== lamps_first) toggled = 1'h1;
                if (m == 1) lamps_exp = {det_led, det_led};
                else if (m == 2) lamps_exp = {det_led, ~det_led};
                else lamps_exp = 2'h3;
                `CHECK("lamps", lamps_exp, {det_led, switch_indicator_led})
            end
            `CHECK("lamp blink", (m != 3), toggled)
        end
        conclude();
    end
endmodule : testbench
`default_nettype wire
